// file: design/flash_charge_controller.sv
`timescale 1ns/10ps
// Behaviour
// - Gate output follows flash trigger only while charge request is low.
// - Charge-done is open drain, pulled low once the capacitor is full.
// - Charge-done stays released while charging and during any fault.
// - Charge-done is released when the charge request falls.
// - One charge enable latch holds the on/off charging state.
// - Only a rising charge request sets the latch and starts a run.
// - Latch clears on request low, full charge, or switch overvoltage.
// - Full-voltage report stops charging and asserts charge-done.
// - After overvoltage fault, charge-done never asserts while request stays high.
// - During on phase, peak-current report turns the switch off.
// - During off phase, zero-kickback report turns the switch back on.
// - During off phase, full-voltage report ends charging.
// - On phase longer than the on limit forces the switch off.
// - Off phase longer than the off limit forces the switch on.
// - Overvoltage during the on phase latches the device off.
// - Over-temperature stops everything; resumes when cool if request stayed high.
module flash_charge_controller
   import flash_charge_pkg::*;
#(
   parameter int MAX_ON_CYCLES = MAX_ON_CYC,
   parameter int MAX_OFF_CYCLES = MAX_OFF_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Host pins
   input wire logic charge_request,
   input wire logic flash_trigger,
   // Analog comparator reports
   input wire comparator_s cmp_in,
   // Power stage drives
   output logic primary_switch,
   output logic flash_gate_drive,
   // Open-drain charge-done pin; enable low pulls the pin low
   output logic charge_done_n_out,
   output logic charge_done_n_oe_n,
   // Status
   output logic charge_enable_latch,
   output logic switch_overvoltage_fault
);
   // ============================================================
   // Input synchronisation
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] syn;
   logic req_s;
   logic trig_s;
   logic hot_s;

   assign raw_in = {flash_trigger, charge_request, cmp_in.over_temp, cmp_in.switch_ov,
                    cmp_in.peak_current, cmp_in.zero_kickback, cmp_in.full_voltage};

   input_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(raw_in),
      .sync_out(syn)
   );

   assign req_s = syn[SB_REQ];
   assign trig_s = syn[SB_TRIG];
   assign hot_s = syn[SB_HOT];

   // ============================================================
   // State
   logic req_d_r;
   logic en_r, en_nxt;
   logic ovf_r, ovf_nxt;
   logic done_r, done_nxt;
   phase_e phase_r, phase_nxt;
   logic [TMR_W-1:0] cnt_r, cnt_nxt;
   logic sw_r, sw_nxt;
   logic gate_r, gate_nxt;
   logic oe_n_r, oe_n_nxt;
   logic req_rise;
   logic req_fall;
   logic full_evt;
   logic ov_evt;
   logic on_expired;
   logic off_expired;

   // Edges seen on the synchronised request only
   assign req_rise = req_s && !req_d_r;
   assign req_fall = !req_s && req_d_r;

   // Timer limits; a phase ends in the cycle its count reaches limit minus one
   assign on_expired = (cnt_r >= TMR_W'(MAX_ON_CYCLES - 1));
   assign off_expired = (cnt_r >= TMR_W'(MAX_OFF_CYCLES - 1));

   // Full charge is only judged on the kickback, so only in the off phase.
   // A falling request ends the run first, so done can never outlive it.
   assign full_evt = en_r && req_s && !hot_s && (phase_r == PH_OFF) && syn[SB_FULL];
   // Switch node overvoltage is only meaningful while the switch conducts
   assign ov_evt = en_r && (phase_r == PH_ON) && syn[SB_SWOV];

   // ============================================================
   // Enable latch, fault latch and charge-done flag
   always_comb begin
      // A new run wins over a same-cycle stop event
      if (req_rise) begin
         en_nxt = 1'b1;
      end else if (!req_s || full_evt || ov_evt) begin
         en_nxt = 1'b0;
      end else begin
         en_nxt = en_r;
      end
      // Fault set wins; a fresh run clears it
      if (ov_evt) begin
         ovf_nxt = 1'b1;
      end else if (req_rise) begin
         ovf_nxt = 1'b0;
      end else begin
         ovf_nxt = ovf_r;
      end
      // Done flag set by full charge, cleared by request fall or new run
      if (full_evt) begin
         done_nxt = 1'b1;
      end else if (req_fall || req_rise) begin
         done_nxt = 1'b0;
      end else begin
         done_nxt = done_r;
      end
   end

   // ============================================================
   // Switching phase sequencer with on and off time limits
   always_comb begin
      phase_nxt = phase_r;
      cnt_nxt = cnt_r + TMR_ONE;
      case (phase_r)
         PH_IDLE: begin
            cnt_nxt = TMR_ZERO;
            if (en_nxt && !hot_s) begin
               phase_nxt = PH_ON;
            end
         end
         PH_ON: begin
            if (syn[SB_PEAK] || on_expired) begin
               phase_nxt = PH_OFF;
               cnt_nxt = TMR_ZERO;
            end
         end
         PH_OFF: begin
            if (syn[SB_ZERO] || off_expired) begin
               phase_nxt = PH_ON;
               cnt_nxt = TMR_ZERO;
            end
         end
         default: begin
            phase_nxt = PH_IDLE;
            cnt_nxt = TMR_ZERO;
         end
      endcase
      // Stop or heat drops to idle; the latch survives heat so charging resumes
      if (!en_nxt || hot_s) begin
         phase_nxt = PH_IDLE;
         cnt_nxt = TMR_ZERO;
      end
   end

   // ============================================================
   // Registered pin values
   always_comb begin
      sw_nxt = (phase_nxt == PH_ON);
      gate_nxt = trig_s && !req_s && !hot_s;
      // Released during heat and after a fault, pulled low only when done
      oe_n_nxt = !(done_nxt && !hot_s && !ovf_nxt);
   end

   // State registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         req_d_r <= 1'b0;
         en_r <= 1'b0;
         ovf_r <= 1'b0;
         done_r <= 1'b0;
         phase_r <= PH_IDLE;
         cnt_r <= TMR_ZERO;
         sw_r <= 1'b0;
         gate_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         req_d_r <= req_s;
         en_r <= en_nxt;
         ovf_r <= ovf_nxt;
         done_r <= done_nxt;
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         sw_r <= sw_nxt;
         gate_r <= gate_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   // Outputs straight from flip-flops; pin level when driven is always low
   assign primary_switch = sw_r;
   assign flash_gate_drive = gate_r;
   assign charge_done_n_out = 1'b0;
   assign charge_done_n_oe_n = oe_n_r;
   assign charge_enable_latch = en_r;
   assign switch_overvoltage_fault = ovf_r;

   // ============================================================
   // Assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence on_peak_seq;
      (phase_r == PH_ON) && syn[SB_PEAK];
   endsequence

   sequence off_zero_seq;
      (phase_r == PH_OFF) && syn[SB_ZERO] && !syn[SB_FULL] && req_s && !hot_s && !req_rise;
   endsequence

   sequence on_timeout_seq;
      (phase_r == PH_ON) && (cnt_r == TMR_W'(MAX_ON_CYCLES - 1));
   endsequence

   sequence off_timeout_seq;
      (phase_r == PH_OFF) && (cnt_r == TMR_W'(MAX_OFF_CYCLES - 1)) && !syn[SB_FULL]
         && req_s && !hot_s;
   endsequence

   gate_needs_low_a: assert property (flash_gate_drive |-> !$past(req_s) && $past(trig_s))
      else $error("gate driven while request high or trigger low");
   // Done may come back after cooling while the run stays finished
   done_from_full_a: assert property ($fell(charge_done_n_oe_n) |-> $past(full_evt)
      || ($past(done_r) && $past(hot_s, 2)))
      else $error("charge-done pulled low without full charge");
   done_released_run_a: assert property ((phase_r != PH_IDLE) |-> charge_done_n_oe_n)
      else $error("charge-done pulled low while charging");
   done_clear_fall_a: assert property ($fell(req_s) |=> charge_done_n_oe_n)
      else $error("charge-done not released after request fall");
   rise_sets_latch_a: assert property ($rose(req_s) |=> charge_enable_latch)
      else $error("rising request did not set enable latch");
   full_stops_run_a: assert property (full_evt |=> !charge_enable_latch && !primary_switch
      && !charge_done_n_oe_n)
      else $error("full charge did not stop and flag done");
   fault_blocks_done_a: assert property (switch_overvoltage_fault && req_s |-> charge_done_n_oe_n)
      else $error("charge-done asserted after overvoltage fault");
   peak_turn_off_a: assert property (on_peak_seq |=> !primary_switch)
      else $error("switch stayed on after peak current");
   zero_turn_on_a: assert property (off_zero_seq |=> primary_switch)
      else $error("switch stayed off after zero kickback");
   on_limit_off_a: assert property (on_timeout_seq |=> !primary_switch)
      else $error("on phase exceeded its limit");
   off_limit_on_a: assert property (off_timeout_seq |=> primary_switch)
      else $error("off phase exceeded its limit");
   ov_latch_off_a: assert property (ov_evt |=> switch_overvoltage_fault && !charge_enable_latch
      && !primary_switch)
      else $error("overvoltage did not latch off");
   hot_stops_all_a: assert property (hot_s |=> !primary_switch && !flash_gate_drive)
      else $error("switching or gate active during over-temperature");
   rise_clears_fault_a: assert property ($rose(req_s) |=> !switch_overvoltage_fault)
      else $error("new run did not clear overvoltage fault");
endmodule

// file: design/flash_charge_pkg.sv
// ============================================================
// Shared constants and carriers of the flash charge controller
package flash_charge_pkg;
   // Clock rate in MHz (4 ns period)
   localparam int CLK_MHZ = 250;
   // Longest switch on phase, in microseconds
   localparam int MAX_ON_US = 100;
   // Longest switch off phase, in microseconds
   localparam int MAX_OFF_US = 50;
   // Longest times round down to whole cycles
   localparam int MAX_ON_CYC = MAX_ON_US * CLK_MHZ;
   localparam int MAX_OFF_CYC = MAX_OFF_US * CLK_MHZ;
   // Phase timer width, enough for either limit
   localparam int TMR_W = 16;
   localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
   localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
   // Number of synchronised inputs and their positions
   localparam int SYNC_W = 7;
   localparam int SB_FULL = 0;
   localparam int SB_ZERO = 1;
   localparam int SB_PEAK = 2;
   localparam int SB_SWOV = 3;
   localparam int SB_HOT = 4;
   localparam int SB_REQ = 5;
   localparam int SB_TRIG = 6;
   localparam logic [SYNC_W-1:0] SYNC_RST = 7'h00;

   // Analog comparator outputs as seen by the control logic
   typedef struct packed {
      logic over_temp;
      logic switch_ov;
      logic peak_current;
      logic zero_kickback;
      logic full_voltage;
   } comparator_s;

   // Switching phase, Gray coded along idle, on, off
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_ON = 2'h1,
      PH_OFF = 2'h3
   } phase_e;
endpackage

// file: design/input_sync.sv
`timescale 1ns/10ps
// ============================================================
// Two flip-flop synchroniser bank
module input_sync
   import flash_charge_pkg::*;
#(
   parameter int WIDTH = SYNC_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ============================================================
   // One stage pair per bit; the first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic meta_r;
         logic hold_r;
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               meta_r <= 1'b0;
               hold_r <= 1'b0;
            end else begin
               meta_r <= async_in[i];
               hold_r <= meta_r;
            end
         end
         assign sync_out[i] = hold_r;
      end
   endgenerate
endmodule

// file: test/host_model.sv
`timescale 1ns/10ps
// ============================================================
// Host camera controller: charge request, flash trigger, charge timer
module host_model
#(
   parameter int LIMIT = 300
) (
   // Clock
   input wire logic clk_sys,
   // Charge-done pin level as the host sees it
   input wire logic done_pin,
   // Host pins
   output logic charge_request,
   output logic flash_trigger,
   // Timer state
   output logic timed_out
);
   logic want;
   logic expired;
   int cnt;

   initial begin
      want = 1'b0;
      expired = 1'b0;
      flash_trigger = 1'b0;
      cnt = 0;
   end

   // Request follows the command until the timer gives up on the run
   assign charge_request = want & ~expired;
   assign timed_out = expired;

   // Time from request rise to done low; a stuck run is dropped
   always @(posedge clk_sys) begin
      if (!want) begin
         cnt <= 0;
         expired <= 1'b0;
      end else if (done_pin !== 1'b0 && !expired) begin
         if (cnt == LIMIT - 1) begin
            expired <= 1'b1;
         end
         cnt <= cnt + 1;
      end
   end

   // Callers invoke these right after a rising edge
   task automatic raise();
      want <= 1'b1;
   endtask
   task automatic lower();
      want <= 1'b0;
   endtask
   task automatic fire(input logic v);
      flash_trigger <= v;
   endtask
endmodule

// file: test/tb_flash_charge_controller.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
// ============================================================
// Self-checking bench of the flash charge controller
module tb_flash_charge_controller;
   import flash_charge_pkg::*;
   localparam int ON_CYC = 40;
   localparam int OFF_CYC = 20;
   logic clk_sys, rst_n, charge_request, flash_trigger, timed_out;
   comparator_s cmp;
   logic primary_switch, flash_gate_drive, done_out, done_oe_n, latch, fault, done_pin;
   logic t, r, h;
   int bad_count, checked, n, d;

   // Pull-up on the open-drain done line
   assign done_pin = done_oe_n ? 1'b1 : done_out;

   flash_charge_controller #(.MAX_ON_CYCLES(ON_CYC), .MAX_OFF_CYCLES(OFF_CYC)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .charge_request(charge_request),
      .flash_trigger(flash_trigger), .cmp_in(cmp), .primary_switch(primary_switch),
      .flash_gate_drive(flash_gate_drive), .charge_done_n_out(done_out),
      .charge_done_n_oe_n(done_oe_n), .charge_enable_latch(latch),
      .switch_overvoltage_fault(fault));

   host_model #(.LIMIT(300)) host (.clk_sys(clk_sys), .done_pin(done_pin),
      .charge_request(charge_request), .flash_trigger(flash_trigger),
      .timed_out(timed_out));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Gate level expected from trigger, request and heat
   function automatic logic exp_gate(input logic trig, input logic req, input logic hot);
      return trig & ~req & ~hot;
   endfunction

   // Inputs pass two sync stages and the state register
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask

   // Cycles the switch keeps its present level, bounded
   task automatic run_len(input logic lvl, output int len);
      len = 0;
      while (primary_switch === lvl && len < 1000) begin
         @(posedge clk_sys);
         #1;
         len++;
      end
   endtask

   task automatic finish_test();
      if (bad_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk_sys);
      bad_count++;
      finish_test();
   end

   // ============================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      cmp = '0;
      bad_count = 0;
      checked = 0;
      void'($urandom(32'h5278701D));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      settle();
      `CHK("switch idle", 1'b0, primary_switch)
      `CHK("done idle", 1'b1, done_pin)
      // Rising request starts a run
      @(posedge clk_sys); host.raise();
      settle();
      `CHK("latch set", 1'b1, latch)
      `CHK("switch on", 1'b1, primary_switch)
      `CHK("done charging", 1'b1, done_pin)
      // Without reports each phase lasts exactly its limit
      run_len(1'b1, n);
      `CHK("on length", ON_CYC, n)
      run_len(1'b0, n);
      `CHK("off length", OFF_CYC, n)
      // Peak and zero reports at random points, well inside the limits
      d = $urandom_range(30, 0);
      repeat (d + 1) @(posedge clk_sys);
      cmp.peak_current <= 1'b1;
      settle();
      `CHK("peak off", 1'b0, primary_switch)
      @(posedge clk_sys); cmp.peak_current <= 1'b0;
      d = $urandom_range(13, 0);
      repeat (d + 1) @(posedge clk_sys);
      cmp.zero_kickback <= 1'b1;
      settle();
      `CHK("zero on", 1'b1, primary_switch)
      // Full report in the off phase ends the run and pulls done low
      @(posedge clk_sys); cmp.zero_kickback <= 1'b0; cmp.peak_current <= 1'b1;
      settle();
      @(posedge clk_sys); cmp.peak_current <= 1'b0; cmp.full_voltage <= 1'b1;
      settle();
      `CHK("latch full", 1'b0, latch)
      `CHK("switch full", 1'b0, primary_switch)
      `CHK("done full", 1'b0, done_pin)
      // Done stands; trigger is refused while the request is high
      @(posedge clk_sys); cmp.full_voltage <= 1'b0; host.fire(1'b1);
      settle();
      `CHK("done stands", 1'b0, done_pin)
      `CHK("gate held", 1'b0, flash_gate_drive)
      @(posedge clk_sys); host.lower();
      settle();
      `CHK("done released", 1'b1, done_pin)
      `CHK("gate fires", 1'b1, flash_gate_drive)
      // Overvoltage in the on phase latches the device off
      @(posedge clk_sys); host.fire(1'b0); host.raise();
      settle();
      @(posedge clk_sys); cmp.switch_ov <= 1'b1;
      settle();
      `CHK("fault set", 1'b1, fault)
      `CHK("latch fault", 1'b0, latch)
      `CHK("switch fault", 1'b0, primary_switch)
      // A later full report must not raise done; host timer gives up
      @(posedge clk_sys); cmp.switch_ov <= 1'b0; cmp.full_voltage <= 1'b1;
      repeat (300) @(posedge clk_sys);
      #1;
      `CHK("done after fault", 1'b1, done_pin)
      `CHK("host timeout", 1'b1, timed_out)
      // New rise clears the fault and restarts
      @(posedge clk_sys); cmp.full_voltage <= 1'b0; host.lower();
      @(posedge clk_sys); host.raise();
      settle();
      `CHK("fault cleared", 1'b0, fault)
      `CHK("latch again", 1'b1, latch)
      // Heat stops switching but keeps the latch; cooling resumes
      @(posedge clk_sys); cmp.over_temp <= 1'b1;
      settle();
      `CHK("switch hot", 1'b0, primary_switch)
      `CHK("latch hot", 1'b1, latch)
      @(posedge clk_sys); cmp.over_temp <= 1'b0;
      settle();
      `CHK("switch cool", 1'b1, primary_switch)
      // Random trigger, request and heat against the gate rule
      for (int i = 0; i < 24; i++) begin
         @(posedge clk_sys);
         t = 1'($urandom_range(1, 0));
         r = 1'($urandom_range(1, 0));
         h = 1'($urandom_range(1, 0));
         host.fire(t);
         if (r) host.raise();
         else host.lower();
         cmp.over_temp <= h;
         settle();
         `CHK("gate", exp_gate(t, r, h), flash_gate_drive)
      end
      finish_test();
   end
endmodule
